// ### rtl/cor_regs.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// - first diff register bit 7 picks divider one or three; resets to 1.
// - first diff bits 5:4 pick cmos (00) or hcsl (11); reset 11.
// - first diff bit 1 gives strong cmos drive when set; resets to 0.
// - first diff bit 0 enables the second cmos leg; resets to 0.
// - second diff register bit 7 picks divider one or three; resets to 0.
// - second diff bits 5:4 pick cmos (00) or hcsl (11); reset 11.
// - second diff bit 1 gives strong cmos drive when set; resets to 0.
// - second diff bit 0 enables the second cmos leg; resets to 0.
// - single register bit 7 low powers down the chip; resets to 1.
// - bit 4 low gives 32 kHz; else bit 3 picks divider five or four.
// - bits 1 and 0 enable divider four channels three and two; reset 0.
module cor_regs (
    input wire logic clk, // 100 MHz clock
    input wire logic rst, // sync reset, active high
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte enables
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output logic [1:0] avs_response, // 00 okay, 11 decode error
    output cor_pkg::cor_diff_cfg_t diff_a_cfg, // differential output 1 settings
    output cor_pkg::cor_diff_cfg_t diff_b_cfg, // differential output 2 settings
    output cor_pkg::cor_se_cfg_t se_cfg // single-ended and chip settings
);
    import cor_pkg::*;

    // response codes on the bus
    localparam logic [1:0] RESP_OK = 2'h0; // every mapped access
    localparam logic [1:0] RESP_DECERR = 2'h3; // nothing lives at the address

    // handshake states: idle until a request, then one answer cycle
    typedef enum logic {
        COR_BUS_IDLE,
        COR_BUS_ANSWER
    } cor_bus_state_t;

    // the configuration byte that an access points at
    typedef enum logic [1:0] {
        COR_SEL_NONE,
        COR_SEL_DIFF_ONE,
        COR_SEL_DIFF_TWO,
        COR_SEL_SINGLE
    } cor_reg_sel_t;

    // handshake state
    cor_bus_state_t state_r, state_nxt;
    logic wait_r, wait_nxt;
    logic take, take_write, take_read, lane_ok;

    // register selection and storage
    cor_reg_sel_t sel;
    logic [7:0] diff_one_q, diff_two_q, single_q, sel_q;
    logic wr_one, wr_two, wr_single;

    // read answer
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] resp_r, resp_nxt;

    // decoded settings and their output registers
    cor_diff_cfg_t dec_a, dec_b;
    cor_diff_cfg_t diff_a_r, diff_a_nxt;
    cor_diff_cfg_t diff_b_r, diff_b_nxt;
    cor_se_cfg_t se_r, se_nxt;

    // address decode; each byte address matched exactly, the byte sits in lane 0
    always_comb begin
        unique case (avs_address)
            COR_OFS_DIFF_ONE: begin
                sel = COR_SEL_DIFF_ONE;
            end
            COR_OFS_DIFF_TWO: begin
                sel = COR_SEL_DIFF_TWO;
            end
            COR_OFS_SINGLE: begin
                sel = COR_SEL_SINGLE;
            end
            default: begin
                sel = COR_SEL_NONE; // unmapped: answered with a decode error
            end
        endcase
    end

    // handshake: a request is taken only while idle, so each access counts once
    always_comb begin
        state_nxt = state_r;
        take = 1'b0;
        unique case (state_r)
            COR_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    take = 1'b1;
                    state_nxt = COR_BUS_ANSWER;
                end
            end
            COR_BUS_ANSWER: begin
                state_nxt = COR_BUS_IDLE; // the master drops its request at this edge
            end
        endcase
        wait_nxt = !take; // low only in the cycle after a take
    end

    // handshake registers; waitrequest idles high
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= COR_BUS_IDLE;
            wait_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
        end
    end

    // write strobes; a write stores at the edge that takes it
    always_comb begin
        take_write = take && avs_write;
        take_read = take && avs_read;
        lane_ok = avs_byteenable[0]; // only lane 0 carries a byte
        wr_one = 1'b0;
        wr_two = 1'b0;
        wr_single = 1'b0;
        if (take_write && lane_ok) begin
            unique case (sel)
                COR_SEL_DIFF_ONE: begin
                    wr_one = 1'b1;
                end
                COR_SEL_DIFF_TWO: begin
                    wr_two = 1'b1;
                end
                COR_SEL_SINGLE: begin
                    wr_single = 1'b1;
                end
                COR_SEL_NONE: begin
                    // writes to unmapped offsets are dropped
                end
            endcase
        end
    end

    // the three configuration bytes
    cor_reg8 #(
        .RESET_VAL(COR_RST_DIFF_ONE),
        .WMASK(COR_WMASK_DIFF)
    ) u_diff_one (
        .clk(clk),
        .rst(rst),
        .wr(wr_one),
        .wdata(avs_writedata[7:0]),
        .q(diff_one_q)
    );

    // differential output 2 byte
    cor_reg8 #(
        .RESET_VAL(COR_RST_DIFF_TWO),
        .WMASK(COR_WMASK_DIFF)
    ) u_diff_two (
        .clk(clk),
        .rst(rst),
        .wr(wr_two),
        .wdata(avs_writedata[7:0]),
        .q(diff_two_q)
    );

    // single-ended and divider byte
    cor_reg8 #(
        .RESET_VAL(COR_RST_SINGLE),
        .WMASK(COR_WMASK_SINGLE)
    ) u_single (
        .clk(clk),
        .rst(rst),
        .wr(wr_single),
        .wdata(avs_writedata[7:0]),
        .q(single_q)
    );

    // field decode of both differential bytes
    cor_diff_decode u_dec_a (
        .reg_val(diff_one_q),
        .cfg(dec_a)
    );
    cor_diff_decode u_dec_b (
        .reg_val(diff_two_q),
        .cfg(dec_b)
    );

    // single-ended source and chip power decode
    always_comb begin
        se_nxt.chip_power_down_n = single_q[COR_B_PWR];
        if (!single_q[COR_B_SLOW]) begin
            se_nxt.se_source = COR_SRC_SLOW;
        end else if (single_q[COR_B_SE_SRC]) begin
            se_nxt.se_source = COR_SRC_DIV_FOUR;
        end else begin
            se_nxt.se_source = COR_SRC_DIV_FIVE;
        end
        se_nxt.divider_four_channel_three_enable = single_q[COR_B_CH3];
        se_nxt.divider_four_channel_two_enable = single_q[COR_B_CH2];
    end

    // read mux of the addressed byte
    always_comb begin
        unique case (sel)
            COR_SEL_DIFF_ONE: begin
                sel_q = diff_one_q;
            end
            COR_SEL_DIFF_TWO: begin
                sel_q = diff_two_q;
            end
            COR_SEL_SINGLE: begin
                sel_q = single_q;
            end
            COR_SEL_NONE: begin
                sel_q = '0; // unmapped reads return zero
            end
        endcase
    end

    // read data: latched with the take, standing until the next answer
    always_comb begin
        rdata_nxt = rdata_r;
        if (take) begin
            rdata_nxt = '0;
            if (take_read) begin
                rdata_nxt[7:0] = sel_q;
            end
        end
    end

    // read data register
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // response code: decode error for an unmapped offset, okay otherwise
    always_comb begin
        resp_nxt = resp_r;
        if (take) begin
            resp_nxt = (sel == COR_SEL_NONE) ? RESP_DECERR : RESP_OK;
        end
    end

    // response register
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_r <= RESP_OK;
        end else begin
            resp_r <= resp_nxt;
        end
    end

    // differential output 1 settings follow their byte one cycle late
    always_comb begin
        diff_a_nxt = dec_a;
    end

    // differential output 1 register; cleared while in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            diff_a_r <= '0;
        end else begin
            diff_a_r <= diff_a_nxt;
        end
    end

    // differential output 2 settings follow their byte one cycle late
    always_comb begin
        diff_b_nxt = dec_b;
    end

    // differential output 2 register; cleared while in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            diff_b_r <= '0;
        end else begin
            diff_b_r <= diff_b_nxt;
        end
    end

    // single-ended and chip settings register; powered down while in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            se_r <= '{1'b0, COR_SRC_SLOW, 1'b0, 1'b0};
        end else begin
            se_r <= se_nxt;
        end
    end

    // ports come straight from the registers above
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign avs_response = resp_r;
    assign diff_a_cfg = diff_a_r;
    assign diff_b_cfg = diff_b_r;
    assign se_cfg = se_r;
endmodule

// ### rtl/cor_pkg.sv
package cor_pkg;
    // register offsets (byte addresses on the bus)
    localparam logic [7:0] COR_OFS_DIFF_ONE = 8'h22;
    localparam logic [7:0] COR_OFS_DIFF_TWO = 8'h23;
    localparam logic [7:0] COR_OFS_SINGLE = 8'h24;
    // reset values; reserved bits hold their listed defaults
    localparam logic [7:0] COR_RST_DIFF_ONE = 8'hf4;
    localparam logic [7:0] COR_RST_DIFF_TWO = 8'h74;
    localparam logic [7:0] COR_RST_SINGLE = 8'h8c;
    // writable bit masks; reserved bits are read only
    localparam logic [7:0] COR_WMASK_DIFF = 8'hb3;
    localparam logic [7:0] COR_WMASK_SINGLE = 8'h9b;
    // field positions
    localparam int COR_B_SRC = 7;
    localparam int COR_B_STD_HI = 5;
    localparam int COR_B_STD_LO = 4;
    localparam int COR_B_DRIVE = 1;
    localparam int COR_B_LEG = 0;
    localparam int COR_B_PWR = 7;
    localparam int COR_B_SLOW = 4;
    localparam int COR_B_SE_SRC = 3;
    localparam int COR_B_CH3 = 1;
    localparam int COR_B_CH2 = 0;
    localparam logic [1:0] COR_STD_CMOS = 2'h0;
    localparam logic [1:0] COR_STD_HCSL = 2'h3;

    typedef enum logic [1:0] {
        COR_SRC_SLOW,
        COR_SRC_DIV_FIVE,
        COR_SRC_DIV_FOUR
    } cor_se_src_t;

    // decoded settings of one differential output
    typedef struct packed {
        logic source_div_three;
        logic std_cmos;
        logic std_hcsl;
        logic std_reserved;
        logic drive_strong;
        logic second_leg_en;
    } cor_diff_cfg_t;

    // decoded single-ended and chip-wide settings
    typedef struct packed {
        logic chip_power_down_n;
        cor_se_src_t se_source;
        logic divider_four_channel_three_enable;
        logic divider_four_channel_two_enable;
    } cor_se_cfg_t;
endpackage

// ### rtl/cor_reg8.sv
`timescale 1ns/1ps
module cor_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hff
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic wr, // write strobe
    input wire logic [7:0] wdata, // write data
    output logic [7:0] q // register value
);
    logic [7:0] q_nxt;
    // only writable bits take new data
    always_comb begin
        q_nxt = q;
        if (wr) begin
            q_nxt = (q & ~WMASK) | (wdata & WMASK);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RESET_VAL;
        end else begin
            q <= q_nxt;
        end
    end
endmodule

// ### rtl/cor_diff_decode.sv
`timescale 1ns/1ps
module cor_diff_decode (
    input wire logic [7:0] reg_val, // differential control byte
    output cor_pkg::cor_diff_cfg_t cfg // decoded settings
);
    import cor_pkg::*;
    logic [1:0] std_sel;
    // split the byte into its fields
    always_comb begin
        std_sel = reg_val[COR_B_STD_HI:COR_B_STD_LO];
        cfg.source_div_three = reg_val[COR_B_SRC];
        cfg.std_cmos = (std_sel == COR_STD_CMOS);
        cfg.std_hcsl = (std_sel == COR_STD_HCSL);
        cfg.std_reserved = !cfg.std_cmos && !cfg.std_hcsl;
        // strong drive only matters in cmos mode
        cfg.drive_strong = reg_val[COR_B_DRIVE] && cfg.std_cmos;
        cfg.second_leg_en = reg_val[COR_B_LEG];
    end
endmodule

// ### bench/cor_regs_properties.sv
`timescale 1ns/1ps
module cor_regs_props (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte enables
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic [1:0] avs_response, // response code
    input wire cor_pkg::cor_diff_cfg_t diff_a_cfg, // output 1 settings
    input wire cor_pkg::cor_diff_cfg_t diff_b_cfg, // output 2 settings
    input wire cor_pkg::cor_se_cfg_t se_cfg // single-ended settings
);
    import cor_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // low write byte, looked at two cycles after the write is taken
    wire logic [7:0] wd = avs_writedata[7:0];
    // a write taken at one offset with lane 0 enabled
    sequence wr_at(logic [7:0] a);
        avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == a;
    endsequence
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
    a_a_source: assert property (wr_at(8'h22) |-> ##2 diff_a_cfg.source_div_three == $past(wd[7], 2))
        else $error("output 1 source wrong");
    a_a_standard: assert property (wr_at(8'h22) |-> ##2 diff_a_cfg.std_hcsl == ($past(wd[5:4], 2) == 2'h3)
        && diff_a_cfg.std_cmos == ($past(wd[5:4], 2) == 2'h0)) else $error("output 1 standard wrong");
    a_a_drive_leg: assert property (wr_at(8'h22) |-> ##2 diff_a_cfg.second_leg_en == $past(wd[0], 2)
        && diff_a_cfg.drive_strong == ($past(wd[1], 2) && $past(wd[5:4], 2) == 2'h0)) else $error("output 1 drive");
    a_b_fields: assert property (wr_at(8'h23) |-> ##2 {diff_b_cfg.source_div_three, diff_b_cfg.std_hcsl,
        diff_b_cfg.second_leg_en} == {$past(wd[7], 2), $past(wd[5:4], 2) == 2'h3, $past(wd[0], 2)}) else $error("output 2");
    a_b_drive: assert property (wr_at(8'h23) ##1 1'b1 ##1 $past(wd[5:4], 2) == 2'h0 |-> diff_b_cfg.drive_strong == $past(wd[1], 2))
        else $error("output 2 drive wrong");
    a_power_bit: assert property (wr_at(8'h24) |-> ##2 se_cfg.chip_power_down_n == $past(wd[7], 2))
        else $error("power bit wrong");
    a_se_source: assert property (wr_at(8'h24) |-> ##2 se_cfg.se_source == (!$past(wd[4], 2) ? COR_SRC_SLOW :
        $past(wd[3], 2) ? COR_SRC_DIV_FOUR : COR_SRC_DIV_FIVE)) else $error("single-ended source wrong");
    a_output_divider_four_enables: assert property (wr_at(8'h24) |-> ##2 {se_cfg.divider_four_channel_three_enable, se_cfg.divider_four_channel_two_enable} == $past(wd[1:0], 2))
        else $error("divider four enables wrong");
    a_unmapped_read: assert property (avs_read && avs_waitrequest && avs_address == 8'h25 |=> avs_readdata == 32'h0
        && avs_response == 2'h3) else $error("unmapped read answer wrong");
endmodule
bind cor_regs cor_regs_props i_props (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .diff_a_cfg, .diff_b_cfg, .se_cfg);

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import cor_pkg::*;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [7:0] avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hf;
    logic [1:0] avs_response, rsp;
    cor_diff_cfg_t diff_a_cfg, diff_b_cfg;
    cor_se_cfg_t se_cfg;
    int fails = 0, comparisons = 0, cycles = 0;
    // write data per step and expected decoded settings {src,cmos,hcsl,res,drive,leg}; steps 8 to 11 {pwr,src,ch3,ch2}
    logic [7:0] td [12] = '{8'hff, 8'h00, 8'h03, 8'h10, 8'h80, 8'h00, 8'h33, 8'h20, 8'h00, 8'h1b, 8'h90, 8'h88};
    logic [5:0] tc [12] = '{6'h29, 6'h10, 6'h13, 6'h04, 6'h30, 6'h10, 6'h09, 6'h04, 6'h00, 6'h0b, 6'h14, 6'h10};
    logic [7:0] a, e;
    cor_regs i_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .diff_a_cfg(diff_a_cfg),
        .diff_b_cfg(diff_b_cfg), .se_cfg(se_cfg));
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function automatic logic [31:0] cfg_of(input logic [7:0] ad);
        return ad == 8'h22 ? 32'(diff_a_cfg) : ad == 8'h23 ? 32'(diff_b_cfg) : 32'(se_cfg);
    endfunction
    task automatic complete_run();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // reset values and decoded reset settings
        bus(1'b0, 8'h22, 8'h0, 4'hf); chk(rd, 32'hf4); chk(cfg_of(8'h22), 32'h28);
        bus(1'b0, 8'h23, 8'h0, 4'hf); chk(rd, 32'h74); chk(cfg_of(8'h23), 32'h08);
        bus(1'b0, 8'h24, 8'h0, 4'hf); chk(rd, 32'h8c); chk(cfg_of(8'h24), 32'h10);
        // every code and field, reserved bits held at defaults
        for (int i = 0; i < 12; i++) begin
            a = 8'h22 + 8'(i / 4);
            e = a == 8'h24 ? (COR_RST_SINGLE & ~COR_WMASK_SINGLE) | (td[i] & COR_WMASK_SINGLE)
                : ((a == 8'h22 ? COR_RST_DIFF_ONE : COR_RST_DIFF_TWO) & ~COR_WMASK_DIFF) | (td[i] & COR_WMASK_DIFF);
            bus(1'b1, a, e, 4'hf);
            bus(1'b0, a, 8'h0, 4'hf);
            chk(rd, {24'h0, e});
            chk(cfg_of(a), {26'h0, tc[i]});
            chk({30'h0, rsp}, 32'h0);
        end
        // lane 0 off and unmapped offset leave the byte at 0x22 alone
        bus(1'b1, 8'h22, 8'hc4, 4'he);
        bus(1'b1, 8'h25, 8'hff, 4'hf);
        bus(1'b0, 8'h25, 8'h0, 4'hf); chk({rsp, rd[29:0]}, 32'hc0000000);
        bus(1'b0, 8'h22, 8'h0, 4'hf); chk(rd, 32'h54);
        complete_run();
    end
endmodule
